// ===== shared/see_pkg.sv
// shared constants and types of the serial eeprom command engine
package see_pkg;
  // instruction opcodes after the start bit
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // top two address-field bits under OP_EXT
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;
  // array geometry: 128 words of 16 bits, or 256 bytes
  localparam int unsigned WORDS = 128;
  localparam logic [4:0] DW_X16 = 5'h10;
  localparam logic [4:0] DW_X8 = 5'h08;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int unsigned ADDR_W16_DEF = 8;
  // timing: clock period and self-timed program cycle
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PROG_TIME_MS = 5;
  // longest time, so rounded down
  localparam int unsigned PROG_CYCLES_DEF =
    (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // reset values
  localparam logic WEL_RESET = 1'b0;
  localparam logic OE_N_RESET = 1'b1;
  // decoder states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_DONE = 3'b100
  } see_state_e;
  // self-timed operations
  typedef enum logic [1:0] {
    ENG_WRITE = 2'b00,
    ENG_ERASE = 2'b01,
    ENG_ERASE_ALL = 2'b10,
    ENG_WRITE_ALL = 2'b11
  } see_eng_e;
endpackage

// ===== design/see_engine.sv
// command decoder, read streamer and self-timed program engine
`timescale 1ns/100ps
module see_engine
  import see_pkg::*;
#(
  parameter int unsigned ADDR_W16 = ADDR_W16_DEF,
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // serial pins from the host
  input wire logic chip_select_i,
  input wire logic serial_clock_i,
  input wire logic serial_in_i,
  input wire logic word_organization_select_i,
  // serial output pin, enable active low
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // status
  output logic busy_o
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // refuse address widths and program cycles the engine cannot serve
  if (ADDR_W16 < 7 || ADDR_W16 > 8) begin : g_bad_addr
    $error("address width must be 7 or 8");
  end
  if (PROG_CYCLES <= WORDS + 8) begin : g_bad_prog
    $error("program cycle too short to walk the array");
  end

  see_state_e state, next_state;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [1:0] op, next_op;
  logic [8:0] addr, next_addr;
  logic [15:0] data_sr, next_data_sr;
  logic armed, next_armed;
  see_eng_e arm_op, next_arm_op;
  logic wel, next_wel;
  logic stat_show, next_stat_show;
  logic [8:0] fa, next_fa;
  logic [15:0] sh_word, next_sh_word;
  logic [4:0] sh_cnt, next_sh_cnt;
  logic sh_need, next_sh_need;
  logic next_out, next_oe_n;
  logic cs_q, sk_q;
  logic busy, next_busy;
  logic [CNT_W-1:0] ecnt, next_ecnt;
  see_eng_e e_op, next_e_op;
  logic [8:0] e_addr, next_e_addr;
  logic [15:0] e_data, next_e_data;
  logic [15:0] fifo_mem [2];
  logic wp, rp, next_wp, next_rp;
  logic [1:0] fcnt, next_fcnt;
  logic push, pop, flush, eng_start, write_disable_cmd_hit;
  logic [15:0] mem [WORDS];
  logic mem_we;
  logic [1:0] mem_be;
  logic [6:0] mem_idx;
  logic [15:0] mem_wdata;
  logic x16, sk_rise, cs_fall;
  logic [4:0] aw, dw;
  logic [8:0] a_nx;
  logic [1:0] ext;
  logic [15:0] fetch_word;

  // pins are synchronous to clock_i, so edges come from one stored copy
  assign x16 = word_organization_select_i;
  assign sk_rise = serial_clock_i & ~sk_q;
  assign cs_fall = ~chip_select_i & cs_q;
  assign aw = x16 ? 5'(ADDR_W16) : 5'(ADDR_W16 + 1);
  assign dw = x16 ? DW_X16 : DW_X8;
  assign a_nx = {addr[7:0], serial_in_i};
  assign ext = x16 ? a_nx[ADDR_W16-1 -: 2] : a_nx[ADDR_W16 -: 2];
  // even byte address is the high byte of a word; data left-aligned
  assign fetch_word = x16 ? mem[fa[6:0]] :
    (fa[0] ? {mem[fa[7:1]][7:0], 8'h00} : {mem[fa[7:1]][15:8], 8'h00});

  // decoder, read streamer and two-entry read buffer
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_op = op;
    next_addr = addr;
    next_data_sr = data_sr;
    next_armed = armed;
    next_arm_op = arm_op;
    next_wel = wel;
    next_stat_show = stat_show;
    next_fa = fa;
    next_sh_word = sh_word;
    next_sh_cnt = sh_cnt;
    next_sh_need = sh_need;
    next_out = serial_out_o;
    next_oe_n = serial_out_oe_n_o;
    next_wp = wp;
    next_rp = rp;
    next_fcnt = fcnt;
    // back-pressure: fetching stalls while both entries are full
    push = (state == ST_READ) && (fcnt != 2'h2);
    pop = 1'b0;
    flush = 1'b0;
    eng_start = 1'b0;
    write_disable_cmd_hit = 1'b0;
    // ready status while selected after a cycle
    if (chip_select_i && stat_show) begin
      next_oe_n = 1'b0;
      next_out = ~busy;
    end
    if (!chip_select_i) begin
      next_state = ST_IDLE;
      next_bit_cnt = 5'h00;
      next_oe_n = 1'b1;
      next_out = 1'b0;
      flush = 1'b1;
      next_armed = 1'b0;
      if (cs_fall && armed && !busy) begin
        eng_start = 1'b1;
      end
    end else if (sk_rise && !busy) begin
      unique case (state)
        // wait for the one start bit
        ST_IDLE: begin
          if (serial_in_i) begin
            next_state = ST_HDR;
            next_bit_cnt = 5'h00;
            next_stat_show = 1'b0;
            next_oe_n = 1'b1;
          end
        end
        ST_HDR: begin
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt < 5'h02) begin
            next_op = {op[0], serial_in_i};
          end else begin
            next_addr = a_nx;
          end
          if (bit_cnt == aw + 5'h01) begin
            next_bit_cnt = 5'h00;
            next_state = ST_DONE;
            unique case (op)
              OP_READ: begin
                next_state = ST_READ;
                next_fa = x16 ? {2'h0, a_nx[6:0]} : {1'h0, a_nx[7:0]};
                // leave high impedance with the dummy zero
                next_out = 1'b0;
                next_oe_n = 1'b0;
                next_sh_need = 1'b1;
                flush = 1'b1;
              end
              OP_WRITE: begin
                next_state = ST_DATA;
                next_arm_op = ENG_WRITE;
              end
              // single erase, only with the latch set
              OP_ERASE: begin
                next_armed = wel;
                next_arm_op = ENG_ERASE;
              end
              default: begin
                unique case (ext)
                  EXT_ENABLE: next_wel = 1'b1;
                  EXT_DISABLE: begin
                    next_wel = 1'b0;
                    write_disable_cmd_hit = 1'b1;
                  end
                  EXT_ERASE_ALL: begin
                    next_armed = wel;
                    next_arm_op = ENG_ERASE_ALL;
                  end
                  // write all takes a data word
                  default: begin
                    next_state = ST_DATA;
                    next_arm_op = ENG_WRITE_ALL;
                  end
                endcase
              end
            endcase
          end
        end
        ST_DATA: begin
          next_data_sr = {data_sr[14:0], serial_in_i};
          next_bit_cnt = bit_cnt + 5'h01;
          // armed only with the latch set
          if (bit_cnt == dw - 5'h01) begin
            next_armed = wel;
            next_state = ST_DONE;
          end
        end
        // one output bit per rising serial clock
        ST_READ: begin
          // next word follows the last bit, no dummy
          if (sh_need || sh_cnt == 5'h00) begin
            next_out = fifo_mem[rp][15];
            next_sh_word = {fifo_mem[rp][14:0], 1'b0};
            next_sh_cnt = dw - 5'h01;
            next_sh_need = 1'b0;
            pop = (fcnt != 2'h0);
          end else begin
            next_out = sh_word[15];
            next_sh_word = {sh_word[14:0], 1'b0};
            next_sh_cnt = sh_cnt - 5'h01;
          end
        end
        ST_DONE: begin
          next_state = ST_DONE;
        end
        default: next_state = ST_IDLE;
      endcase
    end
    if (eng_start) begin
      next_stat_show = 1'b1;
    end
    // fetch address walks up and wraps to zero
    if (flush) begin
      next_wp = 1'b0;
      next_rp = 1'b0;
      next_fcnt = 2'h0;
    end else begin
      if (push) begin
        next_wp = ~wp;
        next_fa = x16 ? {2'h0, fa[6:0] + 7'h01} : {1'h0, fa[7:0] + 8'h01};
      end
      if (pop) begin
        next_rp = ~rp;
      end
      next_fcnt = fcnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // self-timed engine: walks all words once, then waits out the cycle
  always_comb begin
    next_busy = busy;
    next_ecnt = ecnt;
    next_e_op = e_op;
    next_e_addr = e_addr;
    next_e_data = e_data;
    mem_we = 1'b0;
    mem_be = 2'h3;
    mem_idx = ecnt[6:0];
    mem_wdata = ERASED_WORD;
    if (eng_start) begin
      next_busy = 1'b1;
      next_ecnt = '0;
      next_e_op = arm_op;
      next_e_addr = addr;
      next_e_data = data_sr;
    end else if (busy) begin
      next_ecnt = ecnt + CNT_W'(1);
      if (ecnt < CNT_W'(WORDS)) begin
        mem_we = (e_op == ENG_ERASE_ALL) || (e_op == ENG_WRITE_ALL) ||
          (mem_idx == (x16 ? e_addr[6:0] : e_addr[7:1]));
        if (!x16 && (e_op == ENG_WRITE || e_op == ENG_ERASE)) begin
          mem_be = e_addr[0] ? 2'h1 : 2'h2;
        end
        // a write replaces the lane whole, no erase needed
        if (e_op == ENG_WRITE || e_op == ENG_WRITE_ALL) begin
          mem_wdata = x16 ? e_data : {e_data[7:0], e_data[7:0]};
        end
      end
      // done inside the program cycle time
      if (ecnt == CNT_W'(PROG_CYCLES - 1)) begin
        next_busy = 1'b0;
      end
    end
  end

  // array and buffer storage, no reset: contents survive like cells
  always_ff @(posedge clock_i) begin
    if (mem_we && mem_be[1]) begin
      mem[mem_idx][15:8] <= mem_wdata[15:8];
    end
    if (mem_we && mem_be[0]) begin
      mem[mem_idx][7:0] <= mem_wdata[7:0];
    end
    if (push) begin
      fifo_mem[wp] <= fetch_word;
    end
  end

  // control registers; reset stands for power-up
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      bit_cnt <= 5'h00;
      op <= 2'h0;
      addr <= 9'h000;
      data_sr <= 16'h0000;
      armed <= 1'b0;
      arm_op <= ENG_WRITE;
      wel <= WEL_RESET;
      stat_show <= 1'b0;
      fa <= 9'h000;
      sh_word <= 16'h0000;
      sh_cnt <= 5'h00;
      sh_need <= 1'b0;
      serial_out_o <= 1'b0;
      serial_out_oe_n_o <= OE_N_RESET;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      busy <= 1'b0;
      busy_o <= 1'b0;
      ecnt <= '0;
      e_op <= ENG_WRITE;
      e_addr <= 9'h000;
      e_data <= 16'h0000;
      wp <= 1'b0;
      rp <= 1'b0;
      fcnt <= 2'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      op <= next_op;
      addr <= next_addr;
      data_sr <= next_data_sr;
      armed <= next_armed;
      arm_op <= next_arm_op;
      // only a disable command or reset clears it
      wel <= next_wel;
      stat_show <= next_stat_show;
      fa <= next_fa;
      sh_word <= next_sh_word;
      sh_cnt <= next_sh_cnt;
      sh_need <= next_sh_need;
      serial_out_o <= next_out;
      serial_out_oe_n_o <= next_oe_n;
      cs_q <= chip_select_i;
      sk_q <= serial_clock_i;
      busy <= next_busy;
      busy_o <= next_busy;
      ecnt <= next_ecnt;
      e_op <= next_e_op;
      e_addr <= next_e_addr;
      e_data <= next_e_data;
      wp <= next_wp;
      rp <= next_rp;
      fcnt <= next_fcnt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_read_start;
    (state == ST_HDR) ##1 (state == ST_READ);
  endsequence
  sequence s_cycle_begin;
    !busy ##1 busy;
  endsequence

  property p_dummy_zero;
    s_read_start |-> (!serial_out_oe_n_o && !serial_out_o);
  endproperty
  a_dummy_zero: assert property (p_dummy_zero)
    else $error("read did not open with a driven zero");

  property p_edge_change;
    ($changed(serial_out_o) && $past(state == ST_READ) && chip_select_i)
      |-> $past(sk_rise);
  endproperty
  a_edge_change: assert property (p_edge_change)
    else $error("read output moved without a serial clock edge");

  // both organizations wrap: last word or last byte back to zero
  property p_wrap;
    (push && !flush && (x16 ? (fa[6:0] == 7'h7f) : (fa[7:0] == 8'hff)))
      |=> (fa == 9'h000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("stream address did not wrap to zero");

  property p_needs_enable;
    s_cycle_begin |-> $past(wel, 2);
  endproperty
  a_needs_enable: assert property (p_needs_enable)
    else $error("program cycle started with latch clear");

  property p_latch_holds;
    (wel && !write_disable_cmd_hit) |=> wel;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("enable latch dropped without disable command");

  property p_self_timed;
    s_cycle_begin |-> busy [*8];
  endproperty
  a_self_timed: assert property (p_self_timed)
    else $error("program cycle ended early");

  property p_erase_ones;
    (mem_we && (e_op == ENG_ERASE || e_op == ENG_ERASE_ALL))
      |-> (mem_wdata == ERASED_WORD);
  endproperty
  a_erase_ones: assert property (p_erase_ones)
    else $error("erase stored a zero bit");

  property p_busy_status;
    (chip_select_i && cs_q && stat_show && busy && state == ST_IDLE)
      |=> (!serial_out_oe_n_o && !serial_out_o);
  endproperty
  a_busy_status: assert property (p_busy_status)
    else $error("busy not shown low on the output");

  property p_cycle_bound;
    (busy && ecnt == CNT_W'(PROG_CYCLES - 1)) |=> !busy;
  endproperty
  a_cycle_bound: assert property (p_cycle_bound)
    else $error("program cycle overran its time");

  property p_ignore_busy;
    busy |-> (state == ST_IDLE) ##1 (state == ST_IDLE || !busy);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("instruction decoded during a program cycle");
endmodule // see_engine

// ===== bench/see_host_model.sv
// host-side serial master model that drives the eeprom pins
`timescale 1ns/100ps
module see_host_model (
  // system clock, used only to pace the pins
  input wire logic clock_i,
  // serial pins toward the device
  output logic chip_select_o,
  output logic serial_clock_o,
  output logic serial_in_o,
  input wire logic serial_out_i
);
  // idle: deselected, serial clock parked low between frames
  initial begin
    chip_select_o = 1'b0;
    serial_clock_o = 1'b0;
    serial_in_o = 1'b0;
  end

  // one bit; q is the output level late in the high phase
  // rising edge sample
  task automatic bit_io(input logic b, output logic q);
    @(negedge clock_i);
    serial_in_o = b;
    repeat (2) @(negedge clock_i);
    serial_clock_o = 1'b1;
    repeat (2) @(negedge clock_i);
    q = serial_out_i;
    serial_clock_o = 1'b0;
  endtask

  // shift n bits msb first
  task automatic send(input logic [31:0] v, input int n, output logic q);
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i], q);
    end
  endtask

  // clock n bits out of the device, msb first
  task automatic recv(input int n, output logic [15:0] d);
    logic q;
    d = 16'h0000;
    for (int i = 0; i < n; i++) begin
      bit_io(1'b0, q);
      d = {d[14:0], q};
    end
  endtask

  // raise chip select off the sampling edge
  task automatic select();
    @(negedge clock_i);
    chip_select_o = 1'b1;
  endtask

  // data line flips so a stale level is never mistaken for data
  // deselect held long
  task automatic deselect();
    @(negedge clock_i);
    chip_select_o = 1'b0;
    serial_in_o = ~serial_in_o;
    repeat (6) @(negedge clock_i);
  endtask

  // start bit, opcode, address; caller keeps ignored top bit at 0
  // header bits
  task automatic cmd(input logic [1:0] op, input logic [8:0] a,
    input int aw, output logic q);
    select();
    send({29'h0, 1'b1, op}, 3, q);
    send({23'h0, a}, aw, q);
  endtask
endmodule // see_host_model

// ===== bench/see_engine_test.sv
// self-checking bench for the serial eeprom command engine
`timescale 1ns/100ps
module see_engine_test;
  import see_pkg::*;
  localparam int unsigned PROG = 200;
  localparam int LIMIT = 30000;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic word_organization_select = 1'b1;
  logic cs;
  logic sk;
  logic di;
  logic dout;
  logic do_line;
  logic oe_n;
  logic busy;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  // short program cycle keeps the run small
  see_engine #(.ADDR_W16(8), .PROG_CYCLES(PROG)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .chip_select_i(cs),
    .serial_clock_i(sk), .serial_in_i(di),
    .word_organization_select_i(word_organization_select), .serial_out_o(dout),
    .serial_out_oe_n_o(oe_n), .busy_o(busy));

  // released pin shows the inverse, so a stale sample cannot pass
  assign do_line = oe_n ? ~dout : dout;

  see_host_model u_host (
    .clock_i(clock_i), .chip_select_o(cs), .serial_clock_o(sk),
    .serial_in_o(di), .serial_out_i(do_line));

  // compare tasks
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // status poll without serial clock edges, bounded wait
  task automatic poll();
    int n;
    n = 0;
    u_host.select();
    repeat (2) @(negedge clock_i);
    chk_bit(oe_n, 1'b0);
    chk_bit(dout, 1'b0);
    while (busy === 1'b1 && n < PROG + 2) begin
      @(negedge clock_i);
      n++;
    end
    chk_bit(busy, 1'b0);
    @(negedge clock_i);
    chk_bit(dout, 1'b1);
    u_host.deselect();
  endtask

  // instruction that may launch a cycle; go says whether it should
  task automatic prog(input logic [1:0] op, input logic [8:0] a,
    input int aw, input logic [15:0] d, input int dw, input logic go);
    logic q;
    u_host.cmd(op, a, aw, q);
    if (dw > 0)
      u_host.send({16'h0, d}, dw, q);
    u_host.deselect();
    chk_bit(busy, go);
    if (go)
      poll();
  endtask

  task automatic ext(input logic [1:0] code, input logic [15:0] d,
    input int dw, input logic go);
    prog(OP_EXT, {1'b0, code, 6'h2a}, 8, d, dw, go);
  endtask

  // read header, then first word; stays selected for streaming
  task automatic rd(input logic [8:0] a, input int aw, input int dw,
    output logic [15:0] d);
    logic q;
    u_host.cmd(OP_READ, a, aw, q);
    chk_bit(oe_n, 1'b0);
    chk_bit(q, 1'b0);
    u_host.recv(dw, d);
  endtask

  // writes and erases refused after power-up
  task automatic t_power_up();
    chk_bit(oe_n, 1'b1);
    prog(OP_WRITE, 9'h003, 8, 16'h1111, 16, 1'b0);
    prog(OP_ERASE, 9'h003, 8, 16'h0000, 0, 1'b0);
    ext(EXT_WRITE_ALL, 16'h2222, 16, 1'b0);
  endtask

  // write, overwrite without erase, read back
  task automatic t_write_read();
    logic [15:0] d;
    ext(EXT_ENABLE, 16'h0000, 0, 1'b0);
    prog(OP_WRITE, 9'h005, 8, 16'ha5c3, 16, 1'b1);
    prog(OP_WRITE, 9'h005, 8, 16'h5a3c, 16, 1'b1);
    rd(9'h005, 8, 16, d);
    chk_word(d, 16'h5a3c);
    u_host.deselect();
    chk_bit(oe_n, 1'b1);
  endtask

  // instruction shifted while busy is ignored
  task automatic t_busy_ignore();
    logic q;
    logic [15:0] d;
    u_host.cmd(OP_WRITE, 9'h006, 8, q);
    u_host.send({16'h0, 16'h6e6e}, 16, q);
    u_host.deselect();
    u_host.cmd(OP_READ, 9'h005, 8, q);
    chk_bit(busy, 1'b1);
    chk_bit(q, 1'b0);
    poll();
    rd(9'h006, 8, 16, d);
    chk_word(d, 16'h6e6e);
    u_host.deselect();
  endtask

  task automatic t_erase();
    logic [15:0] d;
    prog(OP_ERASE, 9'h006, 8, 16'h0000, 0, 1'b1);
    rd(9'h006, 8, 16, d);
    chk_word(d, ERASED_WORD);
    u_host.deselect();
  endtask

  // stream from the last word wraps to word 0, no second dummy
  task automatic t_wrap();
    logic [15:0] d;
    prog(OP_WRITE, 9'h07f, 8, 16'h1234, 16, 1'b1);
    prog(OP_WRITE, 9'h000, 8, 16'habcd, 16, 1'b1);
    rd(9'h07f, 8, 16, d);
    chk_word(d, 16'h1234);
    u_host.recv(16, d);
    chk_word(d, 16'habcd);
    u_host.deselect();
  endtask

  // write-all, then byte mode access and byte stream
  task automatic t_all_x8();
    logic [15:0] d;
    ext(EXT_WRITE_ALL, 16'h0f0f, 16, 1'b1);
    rd(9'h04d, 8, 16, d);
    chk_word(d, 16'h0f0f);
    u_host.deselect();
    word_organization_select = 1'b0;
    prog(OP_WRITE, 9'h009, 9, 16'h003c, 8, 1'b1);
    rd(9'h008, 9, 8, d);
    chk_word(d, 16'h000f);
    u_host.recv(8, d);
    chk_word(d, 16'h003c);
    u_host.deselect();
    word_organization_select = 1'b1;
  endtask

  // erase-all, disable blocks writes, reads still work
  task automatic t_disable();
    logic [15:0] d;
    ext(EXT_ERASE_ALL, 16'h0000, 0, 1'b1);
    ext(EXT_DISABLE, 16'h0000, 0, 1'b0);
    prog(OP_WRITE, 9'h003, 8, 16'h0000, 16, 1'b0);
    rd(9'h003, 8, 16, d);
    chk_word(d, ERASED_WORD);
    u_host.deselect();
  endtask

  // second power-up leaves writes disabled
  task automatic t_reset_again();
    ext(EXT_ENABLE, 16'h0000, 0, 1'b0);
    rst_n_i = 1'b0;
    repeat (16) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clock_i);
    prog(OP_ERASE, 9'h003, 8, 16'h0000, 0, 1'b0);
  endtask

  // main sequence
  initial begin
    repeat (16) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clock_i);
    t_power_up();
    t_write_read();
    t_busy_ignore();
    t_erase();
    t_wrap();
    t_all_x8();
    t_disable();
    t_reset_again();
    tally_and_finish();
  end
endmodule // see_engine_test
